// ### rtl/uspmb_uart.sv
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/1ps
module uspmb_uart
  import uspmb_pkg::*;
(
  input  wire logic       i_sys_clk,
  input  wire logic       i_resetn,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  input  wire logic       i_serial_in,
  output logic            o_serial_in_out,
  output logic            o_serial_in_oe_n,
  output logic            o_serial_out
);

  typedef struct packed {
    logic [7:0]  ctl;
    logic [7:0]  rbuf;
    logic        baud_doubler;
    logic [7:0]  t1r;
    logic        txc;
    logic        rxc;
    logic [15:0] t2r;
    uspmb_tx_t   txs;
    logic [3:0]  tx_sub;
    logic [3:0]  tx_bit;
    logic [9:0]  tx_sh;
    uspmb_rx_t   rxs;
    logic [3:0]  rx_sub;
    logic [3:0]  rx_bit;
    logic [8:0]  rx_sh;
    logic [1:0]  smp;
    logic        rx_prev;
    logic [3:0]  m0;
    logic        sout;
    logic        sin_o;
    logic        sin_oe_n;
    logic [7:0]  rdata;
  } uspmb_st_t;

  uspmb_st_t   s_r;
  uspmb_st_t   s_nxt;
  uspmb_mode_t mode;
  logic        nine;
  logic        m0_end;
  logic        tx_tick;
  logic        rx_tick;
  logic        ti_set;
  logic        rx_load;
  logic [7:0]  rx_data;
  logic        rx_nine;
  logic [8:0]  sh_n;
  logic        bit_v;
  logic        m0_busy;
  logic [3:0]  tx_last;
  logic [3:0]  rx_last;

  assign mode    = uspmb_mode_t'(s_r.ctl[CTL_MODE_HI:CTL_MODE_LO]);
  assign nine    = s_r.ctl[CTL_MODE_HI];
  assign m0_end  = (s_r.m0 == M0_LAST);
  assign tx_last = uspmb_last(mode);
  assign rx_last = uspmb_last(mode);

  // Timer or fixed-clock sixteen-times ticks per direction
  uspmb_baud u_baud (
    .i_sys_clk   (i_sys_clk),
    .i_resetn    (i_resetn),
    .i_mode      (mode),
    .i_baud_doubler      (s_r.baud_doubler),
    .i_t1_reload (s_r.t1r),
    .i_t2_reload (s_r.t2r),
    .i_tx_t2     (s_r.txc),
    .i_rx_t2     (s_r.rxc),
    .o_tx_tick   (tx_tick),
    .o_rx_tick   (rx_tick)
  );

  // Next state: engines first, bus second, flag sets last
  always_comb begin
    s_nxt   = s_r;
    ti_set  = 1'b0;
    rx_load = 1'b0;
    rx_data = s_r.rx_sh[7:0];
    rx_nine = s_r.rx_sh[8];
    sh_n    = s_r.rx_sh;
    bit_v   = 1'b0;
    m0_busy = 1'b0;
    s_nxt.rdata   = 8'h00;
    s_nxt.rx_prev = i_serial_in;
    // Free twelve-clock bit timebase for shift mode
    s_nxt.m0 = m0_end ? 4'h0 : s_r.m0 + 4'h1; // [RULE_14]
    // Free sub-bit counter so sends align to a tick
    if (tx_tick)
      s_nxt.tx_sub = s_r.tx_sub + 4'h1;

    // Transmit engine
    case (s_r.txs)
      TX_IDLE: begin
        s_nxt.sin_oe_n = 1'b1;
      end
      TX_WAIT: begin
        if (tx_tick && s_r.tx_sub == OVS_LAST) begin // [RULE_10]
          s_nxt.txs    = TX_RUN;
          s_nxt.tx_bit = 4'h0;
          s_nxt.sout   = s_r.tx_sh[0];
        end
      end
      TX_RUN: begin
        if (tx_tick && s_r.tx_sub == OVS_LAST) begin
          if (s_r.tx_bit == tx_last) begin
            s_nxt.txs  = TX_IDLE;
            s_nxt.sout = 1'b1;
          end else begin
            // Ones shift in behind, so the stop slot is high
            s_nxt.tx_sh  = {1'b1, s_r.tx_sh[9:1]}; // [RULE_02] [RULE_09]
            s_nxt.tx_bit = s_r.tx_bit + 4'h1;
            s_nxt.sout   = s_r.tx_sh[1];
            if (s_r.tx_bit + 4'h1 == tx_last)
              ti_set = 1'b1; // [RULE_05]
          end
        end
      end
      TX_M0: begin
        if (m0_end) begin
          if (s_r.tx_bit == M0_BITS) begin
            s_nxt.txs      = TX_IDLE;
            s_nxt.sin_oe_n = 1'b1;
            ti_set         = 1'b1;
          end else begin
            // Data leaves on the serial input pin, LSB first
            s_nxt.sin_o    = s_r.tx_sh[0]; // [RULE_23]
            s_nxt.sin_oe_n = 1'b0;
            s_nxt.tx_sh    = {1'b1, s_r.tx_sh[9:1]};
            s_nxt.tx_bit   = s_r.tx_bit + 4'h1;
          end
        end
      end
      default: begin
        s_nxt.txs = TX_IDLE;
      end
    endcase

    // Receive engine
    case (s_r.rxs)
      RX_IDLE: begin
        if (mode == MODE_SHIFT) begin
          if (s_r.ctl[CTL_REN] && !s_r.ctl[CTL_RXF] &&
              s_r.txs == TX_IDLE) begin // [RULE_01]
            s_nxt.rxs    = RX_M0;
            s_nxt.rx_bit = 4'h0;
          end
        end else if (s_r.ctl[CTL_REN] && s_r.rx_prev &&
                     !i_serial_in) begin // [RULE_06] [RULE_13]
          s_nxt.rxs    = RX_RUN;
          s_nxt.rx_sub = 4'h0;
          s_nxt.rx_bit = 4'h0;
        end
      end
      RX_RUN: begin
        if (rx_tick) begin
          s_nxt.rx_sub = s_r.rx_sub + 4'h1;
          if (s_r.rx_sub >= SMP_FIRST && s_r.rx_sub < SMP_LAST)
            s_nxt.smp = {s_r.smp[0], i_serial_in};
          if (s_r.rx_sub == SMP_LAST) begin
            // Three samples around mid-bit reject glitches
            bit_v = uspmb_maj({s_r.smp, i_serial_in}); // [RULE_24]
            if (s_r.rx_bit != 4'h0 && s_r.rx_bit <= 4'h9)
              sh_n = {bit_v, s_r.rx_sh[8:1]}; // [RULE_06]
            s_nxt.rx_sh  = sh_n;
            s_nxt.rx_bit = s_r.rx_bit + 4'h1;
            if (s_r.rx_bit == 4'h0 && bit_v) begin
              s_nxt.rxs = RX_IDLE; // [RULE_24]
            end else if (s_r.rx_bit == rx_last) begin
              // Taken at mid stop bit; ninth slot feeds the flag bit
              s_nxt.rxs = RX_IDLE;
              rx_data   = sh_n[7:0]; // [RULE_07] [RULE_11]
              rx_nine   = sh_n[8];
              rx_load   = !s_r.ctl[CTL_RXF] &&
                          (!s_r.ctl[CTL_MPF] || sh_n[8]); // [RULE_08]
            end
          end
        end
      end
      RX_M0: begin
        // Sample while the shift clock has just risen
        if (s_r.rx_bit != 4'h0 && s_r.m0 == M0_HALF)
          s_nxt.rx_sh = {i_serial_in, s_r.rx_sh[8:1]}; // [RULE_23]
        if (m0_end) begin
          if (s_r.rx_bit == M0_BITS) begin
            s_nxt.rxs = RX_IDLE;
            rx_data   = s_r.rx_sh[8:1];
            rx_nine   = s_r.ctl[CTL_RX9];
            rx_load   = !s_r.ctl[CTL_RXF]; // [RULE_08]
          end else begin
            s_nxt.rx_bit = s_r.rx_bit + 4'h1;
          end
        end
      end
      default: begin
        s_nxt.rxs = RX_IDLE;
      end
    endcase

    // Register writes
    if (i_wr) begin
      case (i_addr)
        ADDR_SER_CTRL: begin
          s_nxt.ctl = i_wdata; // [RULE_21]
        end
        ADDR_PWR_CTRL: begin
          s_nxt.baud_doubler = i_wdata[PWR_DBL_BIT];
        end
        ADDR_T1_RELOAD: begin
          s_nxt.t1r = i_wdata;
        end
        ADDR_T2_CTRL: begin
          s_nxt.txc = i_wdata[T2_TXC_BIT]; // [RULE_19]
          s_nxt.rxc = i_wdata[T2_RXC_BIT];
        end
        ADDR_T2_RLD_LO: begin
          s_nxt.t2r[7:0] = i_wdata;
        end
        ADDR_T2_RLD_HI: begin
          s_nxt.t2r[15:8] = i_wdata;
        end
        ADDR_SER_BUF: begin
          // Every buffer write sends; a new write restarts
          if (mode == MODE_SHIFT) begin // [RULE_13]
            s_nxt.txs    = TX_M0;
            s_nxt.tx_bit = 4'h0;
            s_nxt.tx_sh  = {2'b11, i_wdata};
            // Shift pins are shared, so a send drops a receive
            s_nxt.rxs    = RX_IDLE;
          end else begin
            s_nxt.txs   = TX_WAIT; // [RULE_04] [RULE_13]
            s_nxt.tx_sh = {nine ? s_r.ctl[CTL_TX9] : 1'b1,
                           i_wdata, 1'b0}; // [RULE_04] [RULE_10]
          end
        end
        default: begin
        end
      endcase
    end

    // Register reads, answered next cycle
    if (i_rd) begin
      case (i_addr)
        ADDR_SER_CTRL: begin
          s_nxt.rdata = s_r.ctl;
        end
        ADDR_SER_BUF: begin
          s_nxt.rdata = s_r.rbuf; // [RULE_22]
        end
        ADDR_PWR_CTRL: begin
          s_nxt.rdata[PWR_DBL_BIT] = s_r.baud_doubler;
        end
        ADDR_T1_RELOAD: begin
          s_nxt.rdata = s_r.t1r;
        end
        ADDR_T2_CTRL: begin
          s_nxt.rdata[T2_TXC_BIT] = s_r.txc;
          s_nxt.rdata[T2_RXC_BIT] = s_r.rxc;
        end
        ADDR_T2_RLD_LO: begin
          s_nxt.rdata = s_r.t2r[7:0];
        end
        ADDR_T2_RLD_HI: begin
          s_nxt.rdata = s_r.t2r[15:8];
        end
        default: begin
        end
      endcase
    end

    // Hardware sets win over a software clear in one cycle
    if (ti_set)
      s_nxt.ctl[CTL_TXF] = 1'b1;
    if (rx_load) begin
      s_nxt.rbuf         = rx_data;
      s_nxt.ctl[CTL_RX9] = rx_nine;
      s_nxt.ctl[CTL_RXF] = 1'b1;
    end

    // Shift clock: low first half of a bit, idles high
    m0_busy = (s_nxt.txs == TX_M0 && s_nxt.tx_bit != 4'h0) ||
              (s_nxt.rxs == RX_M0 && s_nxt.rx_bit != 4'h0);
    if (mode == MODE_SHIFT)
      s_nxt.sout = !m0_busy || s_nxt.m0 >= M0_HALF; // [RULE_01]
    else
      s_nxt.sin_oe_n = 1'b1;
  end

  // All state in one register
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s_r          <= '0;
      s_r.ctl      <= RST_BYTE;
      s_r.t2r      <= RST_RELOAD;
      s_r.sout     <= 1'b1;
      s_r.sin_o    <= 1'b1;
      s_r.sin_oe_n <= 1'b1;
      s_r.rx_prev  <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_rdata          = s_r.rdata;
  assign o_serial_in_out  = s_r.sin_o;
  assign o_serial_in_oe_n = s_r.sin_oe_n;
  assign o_serial_out     = s_r.sout;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);

  sequence s_buf_wr;
    i_wr && i_addr == ADDR_SER_BUF;
  endsequence

  sequence s_clk_hi_lo;
    s_r.sout [*6] ##1 !s_r.sout [*6];
  endsequence

  a_tx_load: assert property ( // [RULE_04]
    s_buf_wr and (mode != MODE_SHIFT) |=> s_r.txs == TX_WAIT &&
    s_r.tx_sh[0] == 1'b0 && s_r.tx_sh[9] == (!nine || s_r.ctl[CTL_TX9]))
    else $error("buffer write did not load the frame");

  a_start_low: assert property ( // [RULE_02]
    s_r.txs == TX_WAIT ##1 s_r.txs == TX_RUN |-> !s_r.sout)
    else $error("start bit not low");

  a_stop_high: assert property ( // [RULE_09]
    s_r.txs == TX_RUN && s_r.tx_bit == tx_last |-> s_r.sout)
    else $error("stop bit not high");

  a_ti_timing: assert property ( // [RULE_05]
    $rose(s_r.ctl[CTL_TXF]) && !$past(i_wr) && s_r.txs == TX_RUN
    |-> s_r.tx_bit == tx_last && $changed(s_r.tx_bit))
    else $error("transmit flag not at stop bit start");

  a_flag_hold: assert property ( // [RULE_21]
    $fell(s_r.ctl[CTL_RXF]) || $fell(s_r.ctl[CTL_TXF])
    |-> $past(i_wr && i_addr == ADDR_SER_CTRL))
    else $error("flag cleared without a control write");

  a_rx_filter: assert property ( // [RULE_08]
    $rose(s_r.ctl[CTL_RXF]) && !$past(i_wr) && mode != MODE_SHIFT
    |-> !s_r.ctl[CTL_MPF] || s_r.ctl[CTL_RX9])
    else $error("filtered frame raised the receive flag");

  a_rx_gate: assert property ( // [RULE_13]
    s_r.rxs == RX_IDLE && !s_r.ctl[CTL_REN] |=> s_r.rxs == RX_IDLE)
    else $error("receive started while disabled");

  a_m0_rx_start: assert property ( // [RULE_01]
    s_r.rxs == RX_IDLE && mode == MODE_SHIFT && s_r.txs == TX_IDLE &&
    s_r.ctl[CTL_REN] && !s_r.ctl[CTL_RXF] && !i_wr |=> s_r.rxs == RX_M0)
    else $error("shift receive did not start");

  a_m0_clock: assert property ( // [RULE_14]
    s_r.txs == TX_M0 && s_r.tx_bit == 4'h2 && $rose(s_r.sout)
    |-> s_clk_hi_lo)
    else $error("shift clock period not twelve");

  a_buf_split: assert property ( // [RULE_22]
    s_buf_wr |=> $stable(s_r.rbuf) || $rose(s_r.ctl[CTL_RXF]))
    else $error("buffer write changed receive data");

endmodule

// ### rtl/uspmb_pkg.sv
// Overview of operation
// [RULE_01] Shift mode receives when enabled and flag clear
// [RULE_02] 8-bit frame: start, eight data, stop
// [RULE_03] 8-bit rate from timer 1 or 2
// [RULE_04] Buffer write sends; stop loaded as ninth
// [RULE_05] Transmit flag set when stop bit starts
// [RULE_06] Async receive starts on falling edge
// [RULE_07] 8-bit receive stores data, stop, flag
// [RULE_08] Store only if flag clear and filter passes
// [RULE_09] 9-bit frame: start, eight, ninth, stop
// [RULE_10] Ninth bit loaded; send at next tick
// [RULE_11] 9-bit receive stores data, ninth, flag
// [RULE_12] Mode three: 9-bit with timer rate
// [RULE_13] Any buffer write sends; async needs enable
// [RULE_14] Shift mode rate is clock over 12
// [RULE_15] Fixed 9-bit rate clock over 64/32
// [RULE_16] Timer 1 rate doubler over 32
// [RULE_17] Software runs timer 1 auto-reload
// [RULE_18] Timer 2 overflows sixteen per bit
// [RULE_19] Timer 2 selects per direction
// [RULE_20] Timer 2 counts every two clocks
// [RULE_21] Flags cleared only by software
// [RULE_22] Buffer write and read are separate
// [RULE_23] Shift mode: eight bits, clock out
// [RULE_24] Sixteen-times sampling, mid-bit majority
package uspmb_pkg;

  // Register port byte addresses
  localparam logic [7:0] ADDR_SER_CTRL  = 8'h98;
  localparam logic [7:0] ADDR_SER_BUF   = 8'h99;
  localparam logic [7:0] ADDR_PWR_CTRL  = 8'h87;
  localparam logic [7:0] ADDR_T1_RELOAD = 8'h8d;
  localparam logic [7:0] ADDR_T2_CTRL   = 8'hc8;
  localparam logic [7:0] ADDR_T2_RLD_LO = 8'hca;
  localparam logic [7:0] ADDR_T2_RLD_HI = 8'hcb;

  // Field positions
  localparam int CTL_MODE_HI = 7;
  localparam int CTL_MODE_LO = 6;
  localparam int CTL_MPF     = 5;
  localparam int CTL_REN     = 4;
  localparam int CTL_TX9     = 3;
  localparam int CTL_RX9     = 2;
  localparam int CTL_TXF     = 1;
  localparam int CTL_RXF     = 0;
  localparam int PWR_DBL_BIT = 7;
  localparam int T2_RXC_BIT  = 5;
  localparam int T2_TXC_BIT  = 4;

  // Reset values
  localparam logic [7:0]  RST_BYTE   = 8'h00;
  localparam logic [15:0] RST_RELOAD = 16'h0000;

  // Timing counts in core clocks or sub-ticks
  localparam logic [3:0] M0_LAST   = 4'hb;
  localparam logic [3:0] M0_HALF   = 4'h6;
  localparam logic [3:0] M0_BITS   = 4'h8;
  localparam logic [3:0] MC_LAST   = 4'hb;
  localparam logic [3:0] OVS_LAST  = 4'hf;
  localparam logic [3:0] SMP_FIRST = 4'h7;
  localparam logic [3:0] SMP_LAST  = 4'h9;
  localparam logic [1:0] FIX_LAST  = 2'h3;

  typedef enum logic [1:0] {
    MODE_SHIFT = 2'b00,
    MODE_8VAR  = 2'b01,
    MODE_9FIX  = 2'b10,
    MODE_9VAR  = 2'b11
  } uspmb_mode_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_WAIT = 2'b01,
    TX_RUN  = 2'b10,
    TX_M0   = 2'b11
  } uspmb_tx_t;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_RUN  = 2'b01,
    RX_M0   = 2'b10
  } uspmb_rx_t;

  // Two of three samples decide the bit
  function automatic logic uspmb_maj(input logic [2:0] v);
    return (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction

  // Index of the last bit slot of an async frame
  function automatic logic [3:0] uspmb_last(input uspmb_mode_t m);
    return m[1] ? 4'ha : 4'h9;
  endfunction

endpackage

// ### rtl/uspmb_baud.sv
`timescale 1ns/1ps
module uspmb_baud
  import uspmb_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_resetn,
  input  wire uspmb_mode_t i_mode,
  input  wire logic        i_baud_doubler,
  input  wire logic [7:0]  i_t1_reload,
  input  wire logic [15:0] i_t2_reload,
  input  wire logic        i_tx_t2,
  input  wire logic        i_rx_t2,
  output logic             o_tx_tick,
  output logic             o_rx_tick
);

  typedef struct packed {
    logic [3:0]  mc;
    logic [7:0]  t1;
    logic        t1_half;
    logic        t2_pre;
    logic [15:0] t2;
    logic [1:0]  fix;
    logic        tx_tick;
    logic        rx_tick;
  } uspmb_bd_t;

  uspmb_bd_t s_r;
  uspmb_bd_t s_nxt;
  logic      t1_ovf;
  logic      t2_ovf;
  logic      t1_tk;
  logic      fix_tk;

  // Ticks are sixteen per bit for every source
  always_comb begin
    s_nxt  = s_r;
    t1_ovf = 1'b0;
    t2_ovf = 1'b0;
    s_nxt.mc = (s_r.mc == MC_LAST) ? 4'h0 : s_r.mc + 4'h1;
    // Timer 1 counts machine cycles, reloads on overflow
    if (s_r.mc == MC_LAST) begin
      if (s_r.t1 == 8'hff) begin
        s_nxt.t1 = i_t1_reload; // [RULE_17]
        t1_ovf   = 1'b1;
      end else begin
        s_nxt.t1 = s_r.t1 + 8'h01;
      end
    end
    if (t1_ovf)
      s_nxt.t1_half = ~s_r.t1_half;
    t1_tk = t1_ovf & (i_baud_doubler | s_r.t1_half); // [RULE_16]
    // Timer 2 runs only as a baud generator here
    if (i_tx_t2 | i_rx_t2) begin // [RULE_19]
      s_nxt.t2_pre = ~s_r.t2_pre;
      if (s_r.t2_pre) begin // [RULE_20]
        if (s_r.t2 == 16'hffff) begin
          s_nxt.t2 = i_t2_reload;
          t2_ovf   = 1'b1; // [RULE_18]
        end else begin
          s_nxt.t2 = s_r.t2 + 16'h0001;
        end
      end
    end else begin
      // Idle timer holds its reload so the first bit is full length
      s_nxt.t2 = i_t2_reload; // [RULE_20]
    end
    s_nxt.fix = s_r.fix + 2'h1;
    fix_tk = i_baud_doubler ? s_r.fix[0] : (s_r.fix == FIX_LAST); // [RULE_15]
    // Per-direction source choice, fixed rate overrides
    if (i_mode == MODE_9FIX) begin
      s_nxt.tx_tick = fix_tk;
      s_nxt.rx_tick = fix_tk;
    end else begin
      s_nxt.tx_tick = i_tx_t2 ? t2_ovf : t1_tk; // [RULE_03] [RULE_12]
      s_nxt.rx_tick = i_rx_t2 ? t2_ovf : t1_tk; // [RULE_03] [RULE_12]
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign o_tx_tick = s_r.tx_tick;
  assign o_rx_tick = s_r.rx_tick;

  a_fix_fast: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (i_mode == MODE_9FIX && i_baud_doubler && s_r.tx_tick)[*2] |-> 1'b0) // [RULE_15]
    else $error("fixed rate tick on two cycles in a row");

endmodule

// ### tb/uspmb_peer.sv
`timescale 1ns/1ps
module uspmb_peer (
  input  wire logic i_sys_clk,
  input  wire logic i_line,
  input  wire logic i_pin,
  input  wire logic i_oe_n,
  output logic      o_drive
);
  logic       m0_en  = 1'b0;
  logic [7:0] m0_tx  = 8'h00;
  logic [7:0] m0_rx  = 8'h00;
  int         m0_n   = 0;
  int         m0_per = 0;
  time        t_last = 0;

  initial o_drive = 1'b1;

  // Shift peripheral puts its next bit out on each falling shift clock
  always @(negedge i_line) begin
    if (m0_en) begin
      o_drive <= m0_tx[m0_n[2:0]];
      m0_n <= m0_n + 1;
    end
  end

  // Period by time stamps, so clock-edge ordering cannot skew it
  always @(posedge i_line) begin
    m0_per <= int'((($time - t_last) / 10));
    t_last <= $time;
    if (!i_oe_n)
      m0_rx <= {i_pin, m0_rx[7:1]};
  end

  // Drive a frame, bit 0 first, then release to idle high
  task automatic send(input int bclk, input int nb, input logic [10:0] v);
    for (int i = 0; i < nb; i++) begin
      o_drive <= v[i];
      repeat (bclk) @(posedge i_sys_clk);
    end
    o_drive <= 1'b1;
  endtask

  // Catch a frame at mid-bit; unsampled upper bits read 1
  task automatic grab(input int bclk, input int nb, output logic [10:0] v);
    v = '1;
    @(negedge i_line);
    repeat (bclk / 2) @(posedge i_sys_clk);
    for (int i = 0; i < nb; i++) begin
      v[i] = i_line;
      if (i < nb - 1)
        repeat (bclk) @(posedge i_sys_clk);
    end
  endtask
endmodule

// ### tb/uspmb_uart_tb_top.sv
`timescale 1ns/1ps
module uspmb_uart_tb_top;
  import uspmb_pkg::*;
  logic       i_sys_clk = 1'b0;
  logic       i_resetn  = 1'b0;
  logic [7:0] i_addr    = 8'h00;
  logic [7:0] i_wdata   = 8'h00;
  logic       i_wr      = 1'b0;
  logic       i_rd      = 1'b0;
  logic [7:0] o_rdata;
  logic       o_serial_in_out;
  logic       o_serial_in_oe_n;
  logic       o_serial_out;
  logic       peer_drv;
  logic       pin;
  logic [7:0] ctl, m_buf, d;
  logic [7:0] m_tx;
  logic       m_rb8, m_ti, m_ri;
  int         error_cnt = 0;
  int         n_checks  = 0;

  always #5 i_sys_clk = ~i_sys_clk;

  // Shared pin: the block wins while its enable is low
  assign pin = o_serial_in_oe_n ? peer_drv : o_serial_in_out;

  uspmb_uart uut (
    .i_sys_clk        (i_sys_clk),
    .i_resetn         (i_resetn),
    .i_addr           (i_addr),
    .i_wdata          (i_wdata),
    .i_wr             (i_wr),
    .i_rd             (i_rd),
    .o_rdata          (o_rdata),
    .i_serial_in      (pin),
    .o_serial_in_out  (o_serial_in_out),
    .o_serial_in_oe_n (o_serial_in_oe_n),
    .o_serial_out     (o_serial_out)
  );

  uspmb_peer peer (
    .i_sys_clk (i_sys_clk),
    .i_line    (o_serial_out),
    .i_pin     (pin),
    .i_oe_n    (o_serial_in_oe_n),
    .o_drive   (peer_drv)
  );

  task automatic results;
    $display("Checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk_reg(input string nm, input logic [7:0] e,
                         input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_pin(input string nm, input logic [10:0] e,
                         input logic [10:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Bus tasks start and end just after a rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
    // One idle edge, so a next write never sets the strobe in this step
    @(posedge i_sys_clk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    @(negedge i_sys_clk);
    v = o_rdata;
    @(posedge i_sys_clk);
  endtask

  // Control write also clears both flags in the model
  task automatic wctl(input logic [7:0] c);
    ctl = c;
    m_ti = 1'b0;
    m_ri = 1'b0;
    wr(ADDR_SER_CTRL, {c[7:3], m_rb8, 2'b00});
  endtask

  task automatic ck_ctl;
    rd(ADDR_SER_CTRL, d);
    chk_reg("control", {ctl[7:3], m_rb8, m_ti, m_ri}, d);
  endtask

  task automatic ck_buf;
    rd(ADDR_SER_BUF, d);
    chk_reg("rx buffer", m_buf, d);
  endtask

  // Poll a control bit; the bound keeps a dead block from hanging
  task automatic poll(input int b);
    int n;
    n = 0;
    d = 8'h00;
    while (d[b] !== 1'b1 && n < 200) begin
      rd(ADDR_SER_CTRL, d);
      n++;
    end
  endtask

  task automatic tx_frame(input int bclk, input logic nine,
                          input logic [7:0] v);
    logic [10:0] got;
    wr(ADDR_SER_BUF, v);
    peer.grab(bclk, nine ? 11 : 10, got);
    chk_pin("tx frame", {1'b1, nine ? ctl[CTL_TX9] : 1'b1, v, 1'b0}, got);
    m_ti = 1'b1;
    ck_ctl;
  endtask

  // Model: store only when enabled, flag clear and filter passes
  task automatic rx_frame(input int bclk, input logic nine,
                          input logic [7:0] v, input logic b9);
    peer.send(bclk, nine ? 11 : 10, {1'b1, b9, v, 1'b0});
    if (ctl[CTL_REN] && !m_ri && (!ctl[CTL_MPF] || b9)) begin
      m_buf = v;
      m_rb8 = b9;
      m_ri = 1'b1;
    end
    ck_buf;
    ck_ctl;
  endtask

  initial begin
    repeat (60000) @(posedge i_sys_clk);
    error_cnt++;
    results;
  end

  initial begin
    ctl = 8'h00;
    m_buf = 8'h00;
    m_rb8 = 1'b0;
    m_ti = 1'b0;
    m_ri = 1'b0;
    void'($urandom(32'h149cdd26));
    repeat (4) @(posedge i_sys_clk);
    i_resetn <= 1'b1;
    @(posedge i_sys_clk);
    ck_ctl;
    ck_buf;
    wr(8'h00, 8'hff);
    rd(8'h00, d);
    chk_reg("unmapped", 8'h00, d);
    wr(ADDR_PWR_CTRL, 8'hff);
    rd(ADDR_PWR_CTRL, d);
    chk_reg("doubler", 8'h80, d);
    // Timer 1 auto-reload at 0xff: one overflow per 12 clocks
    wr(ADDR_T1_RELOAD, 8'hff);
    rd(ADDR_T1_RELOAD, d);
    chk_reg("t1 reload", 8'hff, d);
    // Fixed 9-bit rate, doubled: 32 clocks a bit
    for (int k = 0; k < 2; k++) begin
      wctl({4'b1001, k[0], 3'b000});
      tx_frame(32, 1'b1, 8'($urandom));
      rx_frame(32, 1'b1, 8'($urandom), ~k[0]);
    end
    rx_frame(32, 1'b1, 8'($urandom), 1'b1);
    wctl(8'hb0);
    rx_frame(32, 1'b1, 8'($urandom), 1'b0);
    rx_frame(32, 1'b1, 8'($urandom), 1'b1);
    wr(ADDR_PWR_CTRL, 8'h00);
    tx_frame(64, 1'b1, 8'($urandom));
    wr(ADDR_PWR_CTRL, 8'h80);
    // 8-bit mode on timer 1: 192 clocks a bit
    wctl(8'h50);
    tx_frame(192, 1'b0, 8'($urandom));
    // A short low pulse is no start bit; a later frame must still land
    peer.send(4, 1, 11'h000);
    repeat (200) @(posedge i_sys_clk);
    rx_frame(192, 1'b0, 8'($urandom), 1'b1);
    wctl(8'h70);
    rx_frame(192, 1'b0, 8'($urandom), 1'b0);
    wctl(8'h40);
    rx_frame(192, 1'b0, 8'($urandom), 1'b1);
    wctl(8'hd8);
    tx_frame(192, 1'b1, 8'($urandom));
    rx_frame(192, 1'b1, 8'($urandom), 1'b0);
    // Timer 2 sends at 96 clocks a bit while timer 1 still receives
    wctl(8'hd8);
    wr(ADDR_T2_RLD_LO, 8'hfd);
    wr(ADDR_T2_RLD_HI, 8'hff);
    wr(ADDR_T2_CTRL, 8'h10);
    rd(ADDR_T2_CTRL, d);
    chk_reg("t2 control", 8'h10, d);
    rd(ADDR_T2_RLD_LO, d);
    chk_reg("t2 reload", 8'hfd, d);
    tx_frame(96, 1'b1, 8'($urandom));
    rx_frame(192, 1'b1, 8'($urandom), 1'b1);
    // Shift mode send, then receive from the peripheral
    wctl(8'h00);
    peer.m0_en = 1'b1;
    m_tx = 8'($urandom);
    wr(ADDR_SER_BUF, m_tx);
    poll(CTL_TXF);
    chk_reg("shift out", m_tx, peer.m0_rx);
    chk_pin("shift period", 11'd12, 11'(peer.m0_per));
    // The send must leave the last received byte alone
    ck_buf;
    m_ti = 1'b1;
    ck_ctl;
    peer.m0_tx = 8'($urandom);
    peer.m0_n = 0;
    wctl(8'h10);
    poll(CTL_RXF);
    m_buf = peer.m0_tx;
    m_ri = 1'b1;
    ck_buf;
    ck_ctl;
    results;
  end
endmodule
